// ===== hdl/scb_pkg.sv
// scb_pkg: constants, types and decode helpers for the sensor control bank
// assumes a single 20 MHz core clock and byte-addressed 16-bit registers
package scb_pkg;
  // clock and flash timing
  localparam int unsigned CLK_HZ = 20_000_000; // core clock rate
  localparam int unsigned STORE_TIME_MS = 50; // flash program time
  localparam int unsigned STORE_CYCLES = STORE_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned NV_WRITE_LIMIT = 20_000; // rated endurance, host budget

  // byte addresses, lower byte of each register
  localparam logic [5:0] ADDR_WRITE_COUNT = 6'h00;
  localparam logic [5:0] ADDR_RATE = 6'h04;
  localparam logic [5:0] ADDR_ANGLE = 6'h0E;
  localparam logic [5:0] ADDR_OFFSET = 6'h14;
  localparam logic [5:0] ADDR_GAIN = 6'h16;
  localparam logic [5:0] ADDR_ALM1_THR = 6'h20;
  localparam logic [5:0] ADDR_ALM2_THR = 6'h22;
  localparam logic [5:0] ADDR_ALM1_PER = 6'h24;
  localparam logic [5:0] ADDR_ALM2_PER = 6'h26;
  localparam logic [5:0] ADDR_ALARM_SOURCE_CONTROL = 6'h28;
  localparam logic [5:0] ADDR_AUX = 6'h30;
  localparam logic [5:0] ADDR_PIO = 6'h32;
  localparam logic [5:0] ADDR_MISC = 6'h34;
  localparam logic [5:0] ADDR_SMPL = 6'h36;
  localparam logic [5:0] ADDR_RANGE = 6'h38;
  localparam logic [5:0] ADDR_SLEEP = 6'h3A;
  localparam logic [5:0] ADDR_STATUS = 6'h3C;
  localparam logic [5:0] ADDR_CMD = 6'h3E;

  // reset values
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  localparam logic [15:0] RST_GAIN = 16'h0800; // unity gain
  localparam logic [15:0] RST_ALARM = 16'h0000;
  localparam logic [15:0] RST_AUX = 16'h0000;
  localparam logic [15:0] RST_PIO = 16'h0000;
  localparam logic [15:0] RST_MISC = 16'h0000;
  localparam logic [15:0] RST_SMPL = 16'h0001;
  localparam logic [15:0] RST_RANGE = 16'h0400;
  localparam logic [15:0] RST_SLEEP = 16'h0000;

  // field layouts
  localparam logic [15:0] MASK_12BIT = 16'h0FFF; // trims and converter level
  localparam logic [15:0] MASK_FULL = 16'hFFFF;
  localparam logic [15:0] MASK_MISC_NV = 16'hFF00; // only upper byte kept in flash
  localparam int unsigned GAIN_FRAC_BITS = 11; // 0x0800 is one
  localparam logic [7:0] CMD_USED = 8'h8F;
  localparam int unsigned CMD_NULL = 0;
  localparam int unsigned CMD_RESTORE = 1;
  localparam int unsigned CMD_LATCH = 2;
  localparam int unsigned CMD_STORE = 3;
  localparam int unsigned CMD_SWRST = 7;
  localparam int unsigned STAT_BUSY = 0;

  // serial frame layout
  localparam int unsigned FRM_WR_BIT = 15;
  localparam int unsigned FRM_ZERO_BIT = 14;
  localparam logic [4:0] FRM_LAST = 5'h0F; // bit count of the 16th edge
  localparam logic [2:0] PIN_IDLE = 3'b110; // select high, clock high, data low

  // flash engine states
  typedef enum logic [2:0] {
    SCB_LOAD = 3'b001,
    SCB_IDLE = 3'b010,
    SCB_STORE = 3'b100
  } scb_nv_state_e;

  typedef logic [4:0] scb_idx_t; // word index, byte address over two

  // reset value per word index
  function automatic logic [15:0] scb_rst_val(input scb_idx_t i);
    case (i)
      ADDR_OFFSET[5:1]: return RST_OFFSET;
      ADDR_GAIN[5:1]: return RST_GAIN;
      ADDR_ALM1_THR[5:1], ADDR_ALM2_THR[5:1], ADDR_ALM1_PER[5:1],
      ADDR_ALM2_PER[5:1], ADDR_ALARM_SOURCE_CONTROL[5:1]: return RST_ALARM;
      ADDR_AUX[5:1]: return RST_AUX;
      ADDR_PIO[5:1]: return RST_PIO;
      ADDR_MISC[5:1]: return RST_MISC;
      ADDR_SMPL[5:1]: return RST_SMPL;
      ADDR_RANGE[5:1]: return RST_RANGE;
      ADDR_SLEEP[5:1]: return RST_SLEEP;
      default: return 16'h0000;
    endcase
  endfunction

  // bits software may write
  function automatic logic [15:0] scb_wr_mask(input scb_idx_t i);
    case (i)
      ADDR_OFFSET[5:1], ADDR_GAIN[5:1], ADDR_AUX[5:1]: return MASK_12BIT;
      ADDR_ALM1_THR[5:1], ADDR_ALM2_THR[5:1], ADDR_ALM1_PER[5:1],
      ADDR_ALM2_PER[5:1], ADDR_ALARM_SOURCE_CONTROL[5:1], ADDR_PIO[5:1],
      ADDR_MISC[5:1], ADDR_SMPL[5:1], ADDR_RANGE[5:1],
      ADDR_SLEEP[5:1]: return MASK_FULL;
      default: return 16'h0000;
    endcase
  endfunction

  // bits kept in flash
  function automatic logic [15:0] scb_nv_mask(input scb_idx_t i);
    case (i)
      ADDR_OFFSET[5:1], ADDR_GAIN[5:1], ADDR_ALM1_THR[5:1],
      ADDR_ALM2_THR[5:1], ADDR_ALM1_PER[5:1], ADDR_ALM2_PER[5:1],
      ADDR_ALARM_SOURCE_CONTROL[5:1], ADDR_SMPL[5:1], ADDR_RANGE[5:1]: return MASK_FULL;
      ADDR_MISC[5:1]: return MASK_MISC_NV;
      default: return 16'h0000;
    endcase
  endfunction
endpackage

// ===== hdl/scb_spi_slave.sv
// scb_spi_slave: oversampled four-wire serial port, 16-bit frames, msb first
// assumes sclk idles high, host drives data on falling and samples on rising
module scb_spi_slave import scb_pkg::*; (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic [15:0] tx_word_i,
  output logic [15:0] rx_word_o,
  output logic rx_valid_o,
  output logic dout_o,
  output logic dout_oe_o
);
  logic [2:0] pin_in; // {select, clock, data}
  logic [2:0] s1_ff, s2_ff, s3_ff, lvl_ff, prev_ff;
  logic [15:0] rx_sh_ff, nxt_rx_sh, tx_sh_ff, nxt_tx_sh, rx_word_ff, nxt_rx_word;
  logic [4:0] cnt_ff, nxt_cnt;
  logic rx_valid_ff, nxt_rx_valid, dout_ff, nxt_dout, oe_ff, nxt_oe;
  logic sel, sel_fall, clk_rise, clk_fall;

  assign pin_in = {cs_n_i, sclk_i, din_i};

  // three-stage synchronisers; a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
          s1_ff[g] <= PIN_IDLE[g];
          s2_ff[g] <= PIN_IDLE[g];
          s3_ff[g] <= PIN_IDLE[g];
          lvl_ff[g] <= PIN_IDLE[g];
          prev_ff[g] <= PIN_IDLE[g];
        end else begin
          s1_ff[g] <= pin_in[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          lvl_ff[g] <= (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : lvl_ff[g];
          prev_ff[g] <= lvl_ff[g];
        end
      end
    end
  endgenerate

  assign sel = ~lvl_ff[2];
  assign sel_fall = prev_ff[2] & ~lvl_ff[2];
  assign clk_rise = lvl_ff[1] & ~prev_ff[1];
  assign clk_fall = prev_ff[1] & ~lvl_ff[1];

  // shift engine
  always_comb begin
    nxt_rx_sh = rx_sh_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_cnt = cnt_ff;
    nxt_rx_word = rx_word_ff;
    nxt_rx_valid = 1'b0;
    nxt_dout = dout_ff;
    nxt_oe = sel;
    if (!sel) begin // deselected: output released, count cleared
      nxt_cnt = 5'h00;
    end else if (sel_fall) begin // frame start: preload answer word
      nxt_tx_sh = tx_word_i;
      nxt_dout = tx_word_i[15];
      nxt_cnt = 5'h00;
    end else begin
      if (clk_rise) begin // sample host data
        nxt_rx_sh = {rx_sh_ff[14:0], lvl_ff[0]};
        nxt_cnt = cnt_ff + 5'h01;
        if (cnt_ff == FRM_LAST) begin
          nxt_rx_word = {rx_sh_ff[14:0], lvl_ff[0]};
          nxt_rx_valid = 1'b1;
        end
      end
      if (clk_fall) begin // present next answer bit
        nxt_dout = tx_sh_ff[15];
        nxt_tx_sh = {tx_sh_ff[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rx_sh_ff <= 16'h0000;
      tx_sh_ff <= 16'h0000;
      cnt_ff <= 5'h00;
      rx_word_ff <= 16'h0000;
      rx_valid_ff <= 1'b0;
      dout_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      rx_sh_ff <= nxt_rx_sh;
      tx_sh_ff <= nxt_tx_sh;
      cnt_ff <= nxt_cnt;
      rx_word_ff <= nxt_rx_word;
      rx_valid_ff <= nxt_rx_valid;
      dout_ff <= nxt_dout;
      oe_ff <= nxt_oe;
    end
  end

  assign rx_word_o = rx_word_ff;
  assign rx_valid_o = rx_valid_ff;
  assign dout_o = dout_ff;
  assign dout_oe_o = oe_ff;
endmodule // scb_spi_slave

// ===== hdl/scb_regbank.sv
// scb_regbank: control register bank, rate calibration and global commands
// assumes raw rate samples arrive on the core clock; flash is an array here
//
// Summary of operation
// [RQ1] host keeps flash stores within rated endurance
// [RQ2] readable counter counts every flash store
// [RQ3] reset reloads flash registers, others take defaults
// [RQ4] host holds supply valid through store time
// [RQ5] status read-only, command write-only, others ignored
// [RQ6] misc control: only upper byte kept
// [RQ7] rate out equals raw times gain plus offset
// [RQ8] offset trim: 12-bit signed, flash, reset zero
// [RQ9] gain trim: 12-bit unsigned, unity default
// [RQ10] writing one starts a command, zero nothing
// [RQ11] command bits: 7,3,2,1,0 as listed
// [RQ12] auto null clears the angle output
// [RQ13] auto null trims offset so rate reads zero
// [RQ14] host settles filter before auto null
// [RQ15] restore sets offset zero, gain unity
// [RQ16] manual store copies flash registers, 50 ms
// [RQ17] auto null and restore end with store
// [RQ18] converter output changes only on latch command
// [RQ19] software reset restarts like the reset pin
// [RQ20] write frame: 1, 0, address, data byte
// [RQ21] read frame: 0, 0, address; answer next frame
// [RQ22] either byte address reads the full word
// [RQ23] commands pulse once; unused bits read zero
// [RQ24] stores queue while busy; count per completion
module scb_regbank import scb_pkg::*; #(
  parameter logic [19:0] STORE_WAIT = 20'(STORE_CYCLES) // flash busy cycles
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_din_i,
  input wire logic [13:0] rate_raw_i,
  input wire logic rate_strobe_i,
  input wire logic [15:1] status_flags_i,
  output logic spi_dout_o,
  output logic spi_dout_oe_o,
  output logic [13:0] rate_cal_o,
  output logic [13:0] angle_o,
  output logic [11:0] dac_level_o,
  output logic [15:0] pin_io_control_o,
  output logic [15:0] misc_control_o,
  output logic [15:0] sample_period_o,
  output logic [15:0] range_filter_o,
  output logic [15:0] sleep_duration_o,
  output logic store_busy_o
);
  // word indices of the registers this module touches directly
  localparam scb_idx_t I_CNT = ADDR_WRITE_COUNT[5:1];
  localparam scb_idx_t I_RATE = ADDR_RATE[5:1];
  localparam scb_idx_t I_ANGLE = ADDR_ANGLE[5:1];
  localparam scb_idx_t I_OFF = ADDR_OFFSET[5:1];
  localparam scb_idx_t I_GAIN = ADDR_GAIN[5:1];
  localparam scb_idx_t I_AUX = ADDR_AUX[5:1];
  localparam scb_idx_t I_PIO = ADDR_PIO[5:1];
  localparam scb_idx_t I_MISC = ADDR_MISC[5:1];
  localparam scb_idx_t I_SMPL = ADDR_SMPL[5:1];
  localparam scb_idx_t I_RANGE = ADDR_RANGE[5:1];
  localparam scb_idx_t I_SLEEP = ADDR_SLEEP[5:1];
  localparam scb_idx_t I_STAT = ADDR_STATUS[5:1];
  localparam scb_idx_t I_CMD = ADDR_CMD[5:1];

  logic rst_n_int; // pin reset or software reset
  logic swrst_ff, nxt_swrst;
  logic [15:0] rx_word, tx_ff, nxt_tx, rd_word;
  logic rx_valid, is_wr, is_rd;
  logic [5:0] f_addr;
  scb_idx_t f_idx;
  logic [7:0] f_data;
  logic [7:0] cmd_ff, nxt_cmd; // one-cycle command pulses
  logic [15:0] regs_ff [0:31];
  logic [15:0] nxt_regs [0:31];
  // flash image, survives reset; a blank part holds the defaults, alarms and count zero
  logic [15:0] nv_mem [0:31] = '{I_OFF: RST_OFFSET, I_GAIN: RST_GAIN, I_MISC: RST_MISC,
    I_SMPL: RST_SMPL, I_RANGE: RST_RANGE, default: 16'h0000};
  logic [15:0] cnt_word; // flash write count
  logic [13:0] rate_ff, nxt_rate, rate_calc, angle_ff, nxt_angle;
  logic [11:0] dac_ff, nxt_dac, offs_null;
  logic signed [26:0] prod;
  logic signed [14:0] diff;
  scb_nv_state_e state_ff, nxt_state;
  logic [19:0] wait_ff, nxt_wait;
  logic pend_ff, nxt_pend, auto_ff, nxt_auto, busy_ff, nxt_busy;
  logic st_start, st_done;

  // software reset reaches everything but its own flop and the flash image
  assign rst_n_int = reset_n_i & ~swrst_ff; // RQ19

  scb_spi_slave u_spi (
    .mclk_i(mclk_i),
    .reset_n_i(rst_n_int),
    .cs_n_i(spi_cs_n_i),
    .sclk_i(spi_sclk_i),
    .din_i(spi_din_i),
    .tx_word_i(tx_ff),
    .rx_word_o(rx_word),
    .rx_valid_o(rx_valid),
    .dout_o(spi_dout_o),
    .dout_oe_o(spi_dout_oe_o)
  );

  // frame decode; leading pattern 11 or 01 is dropped
  assign f_addr = rx_word[13:8];
  assign f_idx = f_addr[5:1]; // RQ22
  assign f_data = rx_word[7:0];
  assign is_wr = rx_valid & rx_word[FRM_WR_BIT] & ~rx_word[FRM_ZERO_BIT]; // RQ20
  assign is_rd = rx_valid & ~rx_word[FRM_WR_BIT] & ~rx_word[FRM_ZERO_BIT]; // RQ21
  assign cnt_word = nv_mem[I_CNT];

  // command pulses and software reset
  always_comb begin
    nxt_cmd = 8'h00;
    if (is_wr && f_addr == ADDR_CMD) begin // upper byte address holds nothing
      nxt_cmd = f_data & CMD_USED; // RQ10 RQ11 RQ23
    end
    nxt_swrst = cmd_ff[CMD_SWRST] & ~swrst_ff; // RQ19
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_int) begin
      cmd_ff <= 8'h00;
    end else begin
      cmd_ff <= nxt_cmd;
    end
  end

  // the reset flop itself only answers the pin
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      swrst_ff <= 1'b0;
    end else begin
      swrst_ff <= nxt_swrst;
    end
  end

  // calibration datapath: y = m x + b, gain has 11 fraction bits
  always_comb begin
    prod = $signed(rate_raw_i) * $signed({1'b0, regs_ff[I_GAIN][11:0]});
    // wraps beyond 14 bits; gains near two can overflow full-scale input
    rate_calc = prod[GAIN_FRAC_BITS+13:GAIN_FRAC_BITS]
      + {{2{regs_ff[I_OFF][11]}}, regs_ff[I_OFF][11:0]}; // RQ7
    // new offset cancels the present output, clamped to the trim range
    diff = $signed({{3{regs_ff[I_OFF][11]}}, regs_ff[I_OFF][11:0]})
      - $signed({rate_ff[13], rate_ff});
    if (diff > 15'sd2047) begin
      offs_null = 12'h7FF;
    end else if (diff < -15'sd2048) begin
      offs_null = 12'h800;
    end else begin
      offs_null = diff[11:0]; // RQ13
    end
  end

  // rate, angle and converter latch
  always_comb begin
    nxt_rate = rate_ff;
    nxt_angle = angle_ff;
    nxt_dac = dac_ff;
    if (rate_strobe_i) begin // new sample: update output and integrate
      nxt_rate = rate_calc;
      nxt_angle = angle_ff + rate_calc;
    end
    if (cmd_ff[CMD_NULL]) begin
      nxt_angle = 14'h0000; // RQ12
    end
    if (cmd_ff[CMD_LATCH]) begin
      nxt_dac = regs_ff[I_AUX][11:0]; // RQ18
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_int) begin
      rate_ff <= 14'h0000;
      angle_ff <= 14'h0000;
      dac_ff <= RST_AUX[11:0];
    end else begin
      rate_ff <= nxt_rate;
      angle_ff <= nxt_angle;
      dac_ff <= nxt_dac;
    end
  end

  // register file: reload, byte writes, command side effects
  always_comb begin
    logic [15:0] wm;
    wm = scb_wr_mask(f_idx);
    for (int i = 0; i < 32; i++) begin
      nxt_regs[i] = regs_ff[i];
      if (state_ff == SCB_LOAD) begin // volatile bits keep their defaults
        nxt_regs[i] = (regs_ff[i] & ~scb_nv_mask(5'(i)))
          | (nv_mem[i] & scb_nv_mask(5'(i))); // RQ3 RQ6
      end
    end
    if (is_wr) begin // one byte per frame; read-only bits masked away
      if (f_addr[0]) begin
        nxt_regs[f_idx][15:8] = (f_data & wm[15:8])
          | (regs_ff[f_idx][15:8] & ~wm[15:8]); // RQ5 RQ8 RQ9
      end else begin
        nxt_regs[f_idx][7:0] = (f_data & wm[7:0])
          | (regs_ff[f_idx][7:0] & ~wm[7:0]); // RQ5 RQ23
      end
    end
    if (cmd_ff[CMD_NULL]) begin
      nxt_regs[I_OFF] = {4'h0, offs_null}; // RQ13
    end
    if (cmd_ff[CMD_RESTORE]) begin // restore outranks a null in the same write
      nxt_regs[I_OFF] = RST_OFFSET; // RQ15
      nxt_regs[I_GAIN] = RST_GAIN; // RQ15
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_int) begin
      for (int i = 0; i < 32; i++) begin
        regs_ff[i] <= scb_rst_val(5'(i)); // RQ3
      end
    end else begin
      for (int i = 0; i < 32; i++) begin
        regs_ff[i] <= nxt_regs[i];
      end
    end
  end

  // read answer, shifted out during the next frame
  always_comb begin
    case (f_idx)
      I_CNT: rd_word = cnt_word; // RQ2
      I_RATE: rd_word = {2'b00, rate_ff};
      I_ANGLE: rd_word = {2'b00, angle_ff};
      I_STAT: rd_word = {status_flags_i, state_ff == SCB_STORE};
      I_CMD: rd_word = 16'h0000; // RQ5
      default: rd_word = regs_ff[f_idx]; // unmapped words stay zero, RQ23
    endcase
    nxt_tx = is_rd ? rd_word : tx_ff; // RQ21 RQ22
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_int) begin
      tx_ff <= 16'h0000;
    end else begin
      tx_ff <= nxt_tx;
    end
  end

  // flash engine: reload after reset, then serialised stores
  assign st_start = (state_ff == SCB_IDLE) & pend_ff;
  assign st_done = (state_ff == SCB_STORE) & (wait_ff == 20'h00000);

  always_comb begin
    nxt_state = state_ff;
    nxt_wait = wait_ff;
    nxt_auto = cmd_ff[CMD_NULL] | cmd_ff[CMD_RESTORE]; // RQ17
    // a request in the cycle the queue drains is kept
    nxt_pend = (pend_ff & ~st_start) | cmd_ff[CMD_STORE] | auto_ff; // RQ24
    case (state_ff)
      SCB_LOAD: begin
        nxt_state = SCB_IDLE;
      end
      SCB_IDLE: begin
        if (pend_ff) begin
          nxt_state = SCB_STORE; // RQ16
          nxt_wait = STORE_WAIT - 20'h00001;
        end
      end
      SCB_STORE: begin // further requests wait in pend_ff
        if (wait_ff == 20'h00000) begin
          nxt_state = SCB_IDLE; // RQ24
        end else begin
          nxt_wait = wait_ff - 20'h00001;
        end
      end
      default: begin
        nxt_state = SCB_IDLE;
      end
    endcase
    nxt_busy = (nxt_state == SCB_STORE);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_int) begin
      state_ff <= SCB_LOAD;
      wait_ff <= 20'h00000;
      pend_ff <= 1'b0;
      auto_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
      pend_ff <= nxt_pend;
      auto_ff <= nxt_auto;
      busy_ff <= nxt_busy;
    end
  end

  // flash array: no reset, snapshot at store start, count at completion
  // blank contents come from the declaration, so this process is its only writer
  always_ff @(posedge mclk_i) begin
    if (st_start) begin
      for (int i = 0; i < 32; i++) begin
        if (scb_nv_mask(5'(i)) != 16'h0000) begin
          nv_mem[i] <= regs_ff[i] & scb_nv_mask(5'(i)); // RQ16 RQ6
        end
      end
    end
    if (st_done) begin
      nv_mem[I_CNT] <= nv_mem[I_CNT] + 16'h0001; // RQ2 RQ24
    end
  end

  assign rate_cal_o = rate_ff;
  assign angle_o = angle_ff;
  assign dac_level_o = dac_ff;
  assign pin_io_control_o = regs_ff[I_PIO];
  assign misc_control_o = regs_ff[I_MISC];
  assign sample_period_o = regs_ff[I_SMPL];
  assign range_filter_o = regs_ff[I_RANGE];
  assign sleep_duration_o = regs_ff[I_SLEEP];
  assign store_busy_o = busy_ff;

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_int);

  sequence s_auto_cmd;
    (cmd_ff[CMD_NULL] || cmd_ff[CMD_RESTORE]) && state_ff == SCB_IDLE && !pend_ff;
  endsequence
  sequence s_store_run;
    state_ff == SCB_STORE;
  endsequence

  a_count_step: assert property ( // RQ2
    st_done |=> cnt_word == $past(cnt_word) + 16'h0001)
    else $error("write count did not step on store completion");
  a_reload_gain: assert property ( // RQ3
    state_ff == SCB_LOAD |=> regs_ff[I_GAIN] == $past(nv_mem[I_GAIN]))
    else $error("gain not reloaded from flash");
  a_cmd_read_zero: assert property ( // RQ5
    is_rd && f_idx == I_CMD |=> tx_ff == 16'h0000)
    else $error("command register read not zero");
  a_misc_split: assert property ( // RQ6
    state_ff == SCB_LOAD |=> regs_ff[I_MISC][7:0] == RST_MISC[7:0]
      && regs_ff[I_MISC][15:8] == $past(nv_mem[I_MISC][15:8]))
    else $error("misc control reload wrong");
  a_unity_pass: assert property ( // RQ7
    rate_strobe_i && regs_ff[I_GAIN] == RST_GAIN && regs_ff[I_OFF] == 16'h0000
      && !cmd_ff[CMD_NULL] |=> rate_cal_o == $past(rate_raw_i))
    else $error("unity calibration changed the rate");
  a_trim_width: assert property ( // RQ8 RQ9
    regs_ff[I_OFF][15:12] == 4'h0 && regs_ff[I_GAIN][15:12] == 4'h0)
    else $error("trim upper bits set");
  a_null_angle: assert property ( // RQ12
    cmd_ff[CMD_NULL] |=> angle_o == 14'h0000)
    else $error("angle not cleared by auto null");
  a_restore_vals: assert property ( // RQ15
    cmd_ff[CMD_RESTORE] |=> regs_ff[I_OFF] == RST_OFFSET && regs_ff[I_GAIN] == RST_GAIN)
    else $error("factory restore values wrong");
  a_auto_store: assert property ( // RQ17
    s_auto_cmd |-> ##[2:3] s_store_run)
    else $error("no store after auto null or restore");
  a_latch_hold: assert property ( // RQ18
    // a software reset in the sampled cycle returns the latch to its default
    rst_n_int && !cmd_ff[CMD_LATCH] |=> $stable(dac_level_o))
    else $error("converter output moved without latch");
  a_swrst_restart: assert property ( // RQ19
    @(posedge mclk_i) disable iff (!reset_n_i)
    cmd_ff[CMD_SWRST] |=> !rst_n_int ##1 (state_ff == SCB_LOAD))
    else $error("software reset did not restart");
  a_cmd_single: assert property ( // RQ23
    cmd_ff != 8'h00 |=> cmd_ff == 8'h00)
    else $error("command pulse longer than one cycle");
  a_store_hold: assert property ( // RQ24
    rst_n_int && state_ff == SCB_STORE && wait_ff != 20'h00000 |=> s_store_run)
    else $error("store ended early");
endmodule // scb_regbank

// ===== verif/scb_spi_host.sv
// scb_spi_host: serial host model, 16-bit frames, msb first
// assumes the bench calls xfer from one process only
module scb_spi_host (
  input wire logic mclk_i,
  input wire logic dout_i,
  input wire logic dout_oe_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o,
  output logic [15:0] word_o,
  output logic word_valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_q = 1'b0; // last level the device drove
  // a released answer line must not look like a valid stale bit
  wire line_w = dout_oe_i ? dout_i : ~last_q;
  initial cs_n_o = 1'b1;
  initial sclk_o = 1'b1;
  initial din_o = 1'b0;
  initial word_o = 16'h0000;
  initial word_valid_o = 1'b0;
  // remember the driven level
  always @(posedge mclk_i) begin
    if (dout_oe_i === 1'b1) last_q <= dout_i;
  end
  // one frame; each sclk level held 8 clocks, answer taken at each rise
  task automatic xfer(input logic [15:0] w, input bit keep);
    logic [15:0] r;
    r = 16'h0000;
    @(posedge mclk_i);
    cs_n_o <= 1'b0;
    repeat (8) @(posedge mclk_i);
    for (int i = 15; i >= 0; i--) begin
      sclk_o <= 1'b0;
      din_o <= w[i];
      repeat (8) @(posedge mclk_i);
      sclk_o <= 1'b1;
      r[i] = line_w;
      repeat (8) @(posedge mclk_i);
    end
    cs_n_o <= 1'b1;
    din_o <= ~din_o; // data line toggled after the frame
    word_o <= r;
    word_valid_o <= keep;
    @(posedge mclk_i);
    word_valid_o <= 1'b0;
    repeat (10) @(posedge mclk_i); // select high gap
  endtask
endmodule // scb_spi_host

// ===== verif/scb_regbank_tb.sv
// scb_regbank_tb: self-checking bench for the control bank
// assumes a short flash busy time and the serial host model
module scb_regbank_tb import scb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [19:0] WAITN = 20'd16; // short flash busy time
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] raw = 14'h0000;
  logic strb = 1'b0;
  logic [15:1] flags = 15'h0000;
  logic cs_n, sclk, din, dout, dout_oe, busy, hvalid;
  logic [13:0] rate, angle, r;
  logic [11:0] dac;
  logic [15:0] pio, misc, smpl, rng, slp, hword;
  logic [15:0] expq[$]; // expected answers, oldest first
  logic [31:0] seed = 32'h4051;
  int mismatches = 0;
  int tests_run = 0;
  int n;
  int busy_run = 0; // cycles of the store pulse in progress
  int busy_len = 0; // length of the last finished store pulse
  scb_regbank #(.STORE_WAIT(WAITN)) u_scb_regbank (.mclk_i(mclk), .reset_n_i(rst_n),
    .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_din_i(din), .rate_raw_i(raw),
    .rate_strobe_i(strb), .status_flags_i(flags), .spi_dout_o(dout),
    .spi_dout_oe_o(dout_oe), .rate_cal_o(rate), .angle_o(angle), .dac_level_o(dac),
    .pin_io_control_o(pio), .misc_control_o(misc), .sample_period_o(smpl),
    .range_filter_o(rng), .sleep_duration_o(slp), .store_busy_o(busy));
  scb_spi_host u_scb_spi_host (.mclk_i(mclk), .dout_i(dout), .dout_oe_i(dout_oe),
    .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .word_o(hword), .word_valid_o(hvalid));
  initial forever #25 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_scb_spi_host.xfer({2'b10, a, d}, 1'b0);
  endtask
  // answer of a read arrives in the following frame
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    u_scb_spi_host.xfer({2'b00, a, 8'h00}, 1'b0);
    expq.push_back(e);
    u_scb_spi_host.xfer(16'h0000, 1'b1);
  endtask
  task automatic strobe(input logic [13:0] v);
    @(posedge mclk);
    raw <= v;
    strb <= 1'b1;
    @(posedge mclk);
    strb <= 1'b0;
    #1;
  endtask
  // bounded wait for the flash flag to reach a level
  task automatic wait_busy(input logic v);
    n = 0;
    while (busy !== v) begin
      @(posedge mclk);
      n++;
      if (n > 400) begin
        mismatches++;
        $display("ERROR %0t store flag stuck", $time);
        report_and_stop();
      end
    end
  endtask
  // compare answers in arrival order
  always @(posedge mclk) begin
    if (hvalid === 1'b1 && expq.size() > 0) chk(hword, expq.pop_front());
  end
  // measure each store pulse in clock cycles, independent of when the bench waits
  always @(posedge mclk) begin
    if (busy === 1'b1) busy_run++;
    else if (busy_run > 0) begin
      busy_len = busy_run;
      busy_run = 0;
    end
  end
  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    $display("ERROR %0t run too long", $time);
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(6'h17, RST_GAIN);
    rd(ADDR_OFFSET, RST_OFFSET);
    chk(smpl, RST_SMPL);
    chk(rng, RST_RANGE);
    chk(slp, RST_SLEEP);
    chk(16'(dout_oe), 16'h0000);
    flags <= seed[15:1];
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, {seed[15:1], 1'b0});
    rd(6'h3F, 16'h0000);
    rd(6'h10, 16'h0000);
    $display("test access done");
    seed = lfsr(seed);
    r = {6'h00, seed[7:0]} + 14'd20;
    wr(ADDR_OFFSET, 8'hF0);
    wr(6'h15, 8'h0F);
    strobe(r);
    chk(16'(rate), 16'(r - 14'd16));
    chk(16'(angle), 16'(r - 14'd16));
    wr(ADDR_CMD, 8'h01);
    chk(16'(angle), 16'h0000);
    wait_busy(1'b1);
    wait_busy(1'b0);
    strobe(r);
    chk(16'(rate), 16'h0000);
    rd(ADDR_OFFSET, {4'h0, 12'(-r)});
    $display("test null done");
    wr(ADDR_GAIN, 8'h34);
    wr(6'h17, 8'hFF);
    rd(ADDR_GAIN, 16'h0F34);
    wr(ADDR_CMD, 8'h02);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(6'h17, 16'h0800);
    rd(ADDR_OFFSET, 16'h0000);
    seed = lfsr(seed);
    r = seed[13:0];
    strobe(r);
    chk(16'(rate), 16'(r));
    chk(16'(angle), 16'(r));
    $display("test restore done");
    wr(ADDR_AUX, 8'h56);
    wr(6'h31, 8'h0A);
    chk(16'(dac), 16'h0000);
    wr(ADDR_CMD, 8'h74);
    chk(16'(dac), 16'h0A56);
    chk(16'(busy), 16'h0000);
    $display("test latch done");
    wr(ADDR_MISC, 8'hAB);
    wr(6'h35, 8'hCD);
    wr(ADDR_PIO, 8'h5A);
    chk(misc, 16'hCDAB);
    wr(ADDR_CMD, 8'h08);
    wait_busy(1'b1);
    wait_busy(1'b0);
    @(posedge mclk); // let the pulse meter record the falling edge
    chk(16'(busy_len), 16'(WAITN));
    wr(ADDR_CMD, 8'h80);
    chk(misc, 16'hCD00);
    chk(pio, 16'h0000);
    rd(ADDR_WRITE_COUNT, 16'h0003);
    $display("test store and soft reset done");
    repeat (3) @(posedge mclk);
    report_and_stop();
  end
endmodule // scb_regbank_tb
